// *** rtl/mrs_regs.svh ***
/*
 * register offsets, reset values, limits and timing counts of the fieldbus
 * slave configuration block.
 * assumes a 125 MHz system clock; included by its bare name.
 */
`ifndef MRS_REGS_SVH
`define MRS_REGS_SVH

// ----------------------------------------------------------------------
// register offsets (protocol holding register numbers)
// ----------------------------------------------------------------------
`define MRS_OFS_SLAVE_ADDR   16'h0259
`define MRS_OFS_BIT_RATE     16'h025a
`define MRS_OFS_FRAME_FMT    16'h025b
`define MRS_OFS_LOSS_TMO     16'h025c
`define MRS_OFS_LOSS_ACTION  16'h025d
`define MRS_OFS_RAMP_SRC     16'h025e
`define MRS_OFS_EXTRA_DELAY  16'h025f

// ----------------------------------------------------------------------
// reset values and limits (a lower one for the slave address, upper ones for every field)
// ----------------------------------------------------------------------
`define MRS_RST_SLAVE_ADDR   6'h01
`define MRS_RST_BIT_RATE     3'h5
`define MRS_RST_FRAME_FMT    2'h0
`define MRS_RST_LOSS_TMO     6'h05
`define MRS_RST_LOSS_ACTION  2'h0
`define MRS_RST_RAMP_SRC     1'h0
`define MRS_RST_EXTRA_DELAY  5'h00
`define MRS_MIN_SLAVE_ADDR   16'h0001
`define MRS_MAX_SLAVE_ADDR   16'h003f
`define MRS_MAX_BIT_RATE     16'h0005
`define MRS_MAX_FRAME_FMT    16'h0003
`define MRS_MAX_LOSS_TMO     16'h003c
`define MRS_MAX_LOSS_ACTION  16'h0003
`define MRS_MAX_RAMP_SRC     16'h0001
`define MRS_MAX_EXTRA_DELAY  16'h0010

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define MRS_CLK_HZ           125000000
`define MRS_CLK_PER_SEC      125000000
`define MRS_BAUD_9K6         9600
`define MRS_BAUD_19K2        19200
`define MRS_BAUD_38K4        38400
`define MRS_BAUD_57K6        57600
`define MRS_BAUD_76K8        76800
`define MRS_BAUD_115K        115200
`define MRS_HALF_BIT(b)      ((`MRS_CLK_HZ + 2 * (b) - 1) / (2 * (b)))
`define MRS_MIN_GAP_HALF_CH  10'd7
`define MRS_CHAR_BITS_SHORT  4'd10
`define MRS_CHAR_BITS_LONG   4'd11

`endif

// *** rtl/mrs_pkg.sv ***
/*
 * types shared by the fieldbus slave configuration block.
 * assumes mrs_regs.svh for the numeric constants.
 */
package mrs_pkg;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mrs_reg_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [15:0] rdata;
    } mrs_reg_rsp_t;

    typedef struct packed {
        logic parity_en;
        logic parity_odd;
        logic two_stop;
    } mrs_frame_cfg_t;

    typedef enum logic [3:0] {
        MRS_WD_IDLE = 4'b0001,
        MRS_WD_RUN  = 4'b0010,
        MRS_WD_RAMP = 4'b0100,
        MRS_WD_LOST = 4'b1000
    } mrs_wd_state_t;

endpackage : mrs_pkg

// *** rtl/mrs_char_timer.sv ***
/*
 * half-bit based delay timer used to pace the reply gap.
 * assumes ticks_i is never zero when start_i is raised.
 */
`timescale 1ns/1ps

module mrs_char_timer #(
    parameter int HB_W  = 16,
    parameter int CNT_W = 10
) (
    input  wire logic             clk_sys_i,
    input  wire logic             resetn_i,
    input  wire logic             start_i,
    input  wire logic [HB_W-1:0]  half_bit_cycles_i,
    input  wire logic [CNT_W-1:0] ticks_i,
    output logic                  done_o
);

    logic [HB_W-1:0]  reload;
    logic [HB_W-1:0]  pre;
    logic [CNT_W-1:0] left;
    logic             busy;
    wire              pre_zero = (pre == '0);
    wire              last     = (left == CNT_W'(1));

    // restart on every start, so a newer request supersedes an older gap
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reload <= '0;
            pre    <= '0;
            left   <= '0;
            busy   <= 1'b0;
            done_o <= 1'b0;
        end else if (start_i) begin
            reload <= half_bit_cycles_i - HB_W'(1);
            pre    <= half_bit_cycles_i - HB_W'(1);
            left   <= ticks_i;
            busy   <= 1'b1;
            done_o <= 1'b0;
        end else begin
            done_o <= busy && pre_zero && last;
            if (busy && pre_zero) begin
                pre  <= reload;
                left <= left - CNT_W'(1);
                busy <= !last;
            end else if (busy) begin
                pre <= pre - HB_W'(1);
            end
        end
    end

endmodule : mrs_char_timer

// *** rtl/mrs_comms_cfg.sv ***
/*
 * fieldbus slave configuration and link supervision: holding registers,
 * address filter, reply gap pacing and communication-loss watchdog.
 * assumes a receiver that flags each good telegram with its address and
 * a register port driven by the protocol engine in the clock domain.
 */
`timescale 1ns/1ps
`include "mrs_regs.svh"

module mrs_comms_cfg import mrs_pkg::*; #(
    parameter int CLK_PER_SEC = `MRS_CLK_PER_SEC
) (
    input  wire logic           clk_sys_i,
    input  wire logic           resetn_i,
    input  wire mrs_reg_req_t   reg_req_i,
    output mrs_reg_rsp_t        reg_rsp_o,
    input  wire logic           frame_valid_i,
    input  wire logic [7:0]     frame_addr_i,
    input  wire logic           ramp_done_i,
    output logic                frame_for_me_o,
    output logic                reply_go_o,
    output logic [15:0]         half_bit_cycles_o,
    output mrs_frame_cfg_t      frame_cfg_o,
    output logic                ramp_from_bus_o,
    output logic                comm_loss_o,
    output logic                trip_o,
    output logic                ramp_stop_o,
    output logic                signal_loss_speed_o
);

    // ------------------------------------------------------------------
    // holding registers
    // ------------------------------------------------------------------
    logic [5:0] network_slave_address;
    logic [2:0] serial_bit_rate_select;
    logic [1:0] serial_frame_format;
    logic [5:0] link_loss_timeout;
    logic [1:0] link_loss_action;
    logic       ramp_source_select;
    logic [4:0] reply_extra_delay;

    wire [15:0] wd = reg_req_i.wdata;
    wire hit_addr  = (reg_req_i.addr == `MRS_OFS_SLAVE_ADDR);
    wire hit_rate  = (reg_req_i.addr == `MRS_OFS_BIT_RATE);
    wire hit_fmt   = (reg_req_i.addr == `MRS_OFS_FRAME_FMT);
    wire hit_tmo   = (reg_req_i.addr == `MRS_OFS_LOSS_TMO);
    wire hit_act   = (reg_req_i.addr == `MRS_OFS_LOSS_ACTION);
    wire hit_ramp  = (reg_req_i.addr == `MRS_OFS_RAMP_SRC);
    wire hit_dly   = (reg_req_i.addr == `MRS_OFS_EXTRA_DELAY);
    wire hit_any   = hit_addr | hit_rate | hit_fmt | hit_tmo | hit_act | hit_ramp | hit_dly;

    // out-of-range values are refused whole instead of clipped
    wire ok_addr = (wd >= `MRS_MIN_SLAVE_ADDR) && (wd <= `MRS_MAX_SLAVE_ADDR);
    wire ok_rate = (wd <= `MRS_MAX_BIT_RATE);
    wire ok_fmt  = (wd <= `MRS_MAX_FRAME_FMT);
    wire ok_tmo  = (wd <= `MRS_MAX_LOSS_TMO);
    wire ok_act  = (wd <= `MRS_MAX_LOSS_ACTION);
    wire ok_ramp = (wd <= `MRS_MAX_RAMP_SRC);
    wire ok_dly  = (wd <= `MRS_MAX_EXTRA_DELAY);

    wire val_ok = (hit_addr & ok_addr) | (hit_rate & ok_rate) | (hit_fmt & ok_fmt)
                | (hit_tmo & ok_tmo) | (hit_act & ok_act) | (hit_ramp & ok_ramp)
                | (hit_dly & ok_dly);
    wire do_wr  = reg_req_i.wr && val_ok;

    wire [15:0] rd_mux =
        hit_addr ? {10'h000, network_slave_address}  :
        hit_rate ? {13'h0000, serial_bit_rate_select} :
        hit_fmt  ? {14'h0000, serial_frame_format}    :
        hit_tmo  ? {10'h000, link_loss_timeout}       :
        hit_act  ? {14'h0000, link_loss_action}       :
        hit_ramp ? {15'h0000, ramp_source_select}     :
        hit_dly  ? {11'h000, reply_extra_delay}       : 16'h0000;

    wire        any_req  = reg_req_i.rd | reg_req_i.wr;
    wire        next_err = any_req && (!hit_any || (reg_req_i.wr && !val_ok));

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            network_slave_address  <= `MRS_RST_SLAVE_ADDR;
            serial_bit_rate_select <= `MRS_RST_BIT_RATE;
            serial_frame_format    <= `MRS_RST_FRAME_FMT;
            link_loss_timeout      <= `MRS_RST_LOSS_TMO;
            link_loss_action       <= `MRS_RST_LOSS_ACTION;
            ramp_source_select     <= `MRS_RST_RAMP_SRC;
            reply_extra_delay      <= `MRS_RST_EXTRA_DELAY;
        end else if (do_wr) begin
            if (hit_addr) network_slave_address  <= wd[5:0];
            if (hit_rate) serial_bit_rate_select <= wd[2:0];
            if (hit_fmt)  serial_frame_format    <= wd[1:0];
            if (hit_tmo)  link_loss_timeout      <= wd[5:0];
            if (hit_act)  link_loss_action       <= wd[1:0];
            if (hit_ramp) ramp_source_select     <= wd[0];
            if (hit_dly)  reply_extra_delay      <= wd[4:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rsp_o <= '0;
        end else begin
            reg_rsp_o.ack   <= any_req;
            reg_rsp_o.err   <= next_err;
            reg_rsp_o.rdata <= reg_req_i.rd ? rd_mux : 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // link timing and framing
    // ------------------------------------------------------------------
    logic [15:0] half_bit;

    always_comb begin
        unique case (serial_bit_rate_select)
            3'h0:    half_bit = 16'(`MRS_HALF_BIT(`MRS_BAUD_9K6));
            3'h1:    half_bit = 16'(`MRS_HALF_BIT(`MRS_BAUD_19K2));
            3'h2:    half_bit = 16'(`MRS_HALF_BIT(`MRS_BAUD_38K4));
            3'h3:    half_bit = 16'(`MRS_HALF_BIT(`MRS_BAUD_57K6));
            3'h4:    half_bit = 16'(`MRS_HALF_BIT(`MRS_BAUD_76K8));
            default: half_bit = 16'(`MRS_HALF_BIT(`MRS_BAUD_115K));
        endcase
    end

    mrs_frame_cfg_t next_frame_cfg;
    assign next_frame_cfg.parity_en  = serial_frame_format[1];
    assign next_frame_cfg.parity_odd = (serial_frame_format == 2'h2);
    assign next_frame_cfg.two_stop   = (serial_frame_format == 2'h1);

    // one start, eight data, optional parity, one or two stop bits
    wire [3:0] char_bits = (serial_frame_format == 2'h0) ? `MRS_CHAR_BITS_SHORT
                                                        : `MRS_CHAR_BITS_LONG;

    // gap in half characters: seven (3.5 characters) minimum plus two per extra character
    wire [9:0] gap_half_ch = `MRS_MIN_GAP_HALF_CH + {4'h0, reply_extra_delay, 1'b0};
    // a half character is char_bits half bits, so it tracks the bit rate
    wire [13:0] gap_ticks_w = gap_half_ch * char_bits;
    wire [9:0]  gap_ticks   = gap_ticks_w[9:0];

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            half_bit_cycles_o <= 16'h0000;
            frame_cfg_o       <= '0;
            ramp_from_bus_o   <= 1'b0;
        end else begin
            half_bit_cycles_o <= half_bit;
            frame_cfg_o       <= next_frame_cfg;
            ramp_from_bus_o   <= ramp_source_select;
        end
    end

    // ------------------------------------------------------------------
    // address filter and reply pacing
    // ------------------------------------------------------------------
    // broadcast address is not answered either
    wire addressed = frame_valid_i && (frame_addr_i == {2'b00, network_slave_address});

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            frame_for_me_o <= 1'b0;
        end else begin
            frame_for_me_o <= addressed;
        end
    end

    logic reply_done;

    mrs_char_timer #(
        .HB_W  (16),
        .CNT_W (10)
    ) u_gap (
        .clk_sys_i         (clk_sys_i),
        .resetn_i          (resetn_i),
        .start_i           (addressed),
        .half_bit_cycles_i (half_bit),
        .ticks_i           (gap_ticks),
        .done_o            (reply_done)
    );

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reply_go_o <= 1'b0;
        end else begin
            reply_go_o <= reply_done;
        end
    end

    // ------------------------------------------------------------------
    // communication-loss watchdog
    // ------------------------------------------------------------------
    mrs_wd_state_t state;
    mrs_wd_state_t next_state;
    logic [26:0]   pre_cnt;
    logic [5:0]    sec_cnt;

    wire pre_last  = (pre_cnt == 27'(CLK_PER_SEC - 1));
    wire sec_tick  = (state == MRS_WD_RUN) && pre_last;
    wire wd_enable = (link_loss_timeout != 6'h00);
    wire expire    = wd_enable && sec_tick && ((sec_cnt + 6'h01) >= link_loss_timeout);

    always_comb begin
        next_state = state;
        unique case (state)
            MRS_WD_IDLE: if (addressed) next_state = MRS_WD_RUN;
            MRS_WD_RUN:  if (!addressed && expire) begin
                             next_state = (link_loss_action == 2'h1) ? MRS_WD_RAMP
                                                                    : MRS_WD_LOST;
                         end
            MRS_WD_RAMP: if (addressed) next_state = MRS_WD_RUN;
                         else if (ramp_done_i) next_state = MRS_WD_LOST;
            MRS_WD_LOST: if (addressed) next_state = MRS_WD_RUN;
        endcase
    end

    // counters restart on each telegram addressed to this slave, so a new one always wins over expiry
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state   <= MRS_WD_IDLE;
            pre_cnt <= '0;
            sec_cnt <= '0;
        end else begin
            state <= next_state;
            if (addressed || state != MRS_WD_RUN) begin
                pre_cnt <= '0;
                sec_cnt <= '0;
            end else begin
                pre_cnt <= pre_last ? 27'h0000000 : pre_cnt + 27'h0000001;
                if (sec_tick && sec_cnt != 6'h3f) sec_cnt <= sec_cnt + 6'h01;
            end
        end
    end

    wire enter_loss = (state == MRS_WD_RUN) && (next_state != MRS_WD_RUN);
    wire next_trip  = (enter_loss && link_loss_action == 2'h0)
                    || (state == MRS_WD_RAMP && next_state == MRS_WD_LOST);
    wire next_ramp  = (next_state == MRS_WD_RAMP)
                    || (next_state == MRS_WD_LOST && ramp_stop_o);
    wire next_speed = (enter_loss && link_loss_action == 2'h3)
                    || (next_state == MRS_WD_LOST && signal_loss_speed_o);
    wire next_stop2 = enter_loss && link_loss_action == 2'h2;
    wire next_loss  = (next_state == MRS_WD_RAMP) || (next_state == MRS_WD_LOST);

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            comm_loss_o         <= 1'b0;
            trip_o              <= 1'b0;
            ramp_stop_o         <= 1'b0;
            signal_loss_speed_o <= 1'b0;
        end else begin
            comm_loss_o         <= next_loss;
            trip_o              <= next_trip;
            ramp_stop_o         <= next_ramp || next_stop2;
            signal_loss_speed_o <= next_speed;
        end
    end

endmodule : mrs_comms_cfg

// *** testbench/mrs_comms_cfg_checker.sv ***
/* checker: port-level assertions for mrs_comms_cfg.
   assumes it is bound to every instance by the bind at the foot. */
`timescale 1ns/1ps
module mrs_comms_cfg_checker import mrs_pkg::*; #(
    parameter int CLK_PER_SEC = 125000000
) (
    input wire logic           clk_sys_i,
    input wire logic           resetn_i,
    input wire mrs_reg_req_t   reg_req_i,
    input wire mrs_reg_rsp_t   reg_rsp_o,
    input wire logic           frame_valid_i,
    input wire logic [7:0]     frame_addr_i,
    input wire logic           ramp_done_i,
    input wire logic           frame_for_me_o,
    input wire logic           reply_go_o,
    input wire logic [15:0]    half_bit_cycles_o,
    input wire mrs_frame_cfg_t frame_cfg_o,
    input wire logic           ramp_from_bus_o,
    input wire logic           comm_loss_o,
    input wire logic           trip_o,
    input wire logic           ramp_stop_o,
    input wire logic           signal_loss_speed_o
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    a_ack_next: assert property ((reg_req_i.rd || reg_req_i.wr) |=> reg_rsp_o.ack)
        else $error("register request without ack");
    a_ack_cause: assert property (reg_rsp_o.ack |-> $past(reg_req_i.rd || reg_req_i.wr))
        else $error("ack without request");
    a_err_with_ack: assert property (reg_rsp_o.err |-> reg_rsp_o.ack)
        else $error("err outside ack");
    a_match_cause: assert property (frame_for_me_o |-> $past(frame_valid_i))
        else $error("match without telegram");
    a_addr_zero: assert property ((frame_valid_i && frame_addr_i == 8'h00) |=>
        !frame_for_me_o)
        else $error("address zero accepted");
    a_gap_min: assert property (frame_for_me_o |=> !reply_go_o [*8])
        else $error("reply before gap");
    a_rate_set: assert property ($past(resetn_i) |-> half_bit_cycles_o inside
        {16'h196f, 16'h0cb8, 16'h065c, 16'h043e, 16'h032e, 16'h021f})
        else $error("half bit count not a listed rate");
    a_trip_loss: assert property (trip_o |-> comm_loss_o)
        else $error("trip without link loss");
    a_ramp_write: assert property ($changed(ramp_from_bus_o) |->
        $past(reg_rsp_o.ack) && !$past(reg_rsp_o.err))
        else $error("ramp source moved without write");
    a_fmt_write: assert property ($changed(frame_cfg_o) |-> $past(reg_rsp_o.ack))
        else $error("framing moved without write");
    a_loss_clear: assert property (frame_for_me_o |-> ##[0:2] !comm_loss_o)
        else $error("loss not cleared by telegram");

    c_match: cover property (frame_for_me_o);
    c_reply: cover property (reply_go_o);
    c_trip: cover property (trip_o);
    c_loss: cover property ($rose(comm_loss_o));
endmodule : mrs_comms_cfg_checker

bind mrs_comms_cfg mrs_comms_cfg_checker #(.CLK_PER_SEC(CLK_PER_SEC)) i_chk (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_req_i(reg_req_i),
    .reg_rsp_o(reg_rsp_o), .frame_valid_i(frame_valid_i), .frame_addr_i(frame_addr_i),
    .ramp_done_i(ramp_done_i), .frame_for_me_o(frame_for_me_o), .reply_go_o(reply_go_o),
    .half_bit_cycles_o(half_bit_cycles_o), .frame_cfg_o(frame_cfg_o),
    .ramp_from_bus_o(ramp_from_bus_o), .comm_loss_o(comm_loss_o), .trip_o(trip_o),
    .ramp_stop_o(ramp_stop_o), .signal_loss_speed_o(signal_loss_speed_o));

// *** testbench/mrs_master_model.sv ***
/* model of the bus master: telegrams and register requests.
   assumes its tasks are called from the bench at falling edges. */
`timescale 1ns/1ps
module mrs_master_model import mrs_pkg::*; (
    input  wire logic         clk_sys_i,
    input  wire mrs_reg_rsp_t reg_rsp_i,
    output mrs_reg_req_t      reg_req_o,
    output logic              frame_valid_o,
    output logic [7:0]        frame_addr_o
);
    initial begin
        reg_req_o = '0;
        frame_valid_o = 1'b0;
        frame_addr_o = 8'h00;
    end
    // ----------------------------------------------------------------
    // telegram: one pulse, address scrambled once no longer valid
    // ----------------------------------------------------------------
    task automatic send_frame(input logic [7:0] a);
        @(negedge clk_sys_i);
        frame_valid_o = 1'b1;
        frame_addr_o = a;
        @(negedge clk_sys_i);
        frame_valid_o = 1'b0;
        frame_addr_o = ~a;
    endtask : send_frame
    // ----------------------------------------------------------------
    // register access: one-cycle strobe, answer awaited a bounded time
    // ----------------------------------------------------------------
    task automatic reg_acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                           output logic ok, output logic err, output logic [15:0] q);
        int i;
        ok = 1'b0;
        err = 1'b0;
        q = 16'h0000;
        @(negedge clk_sys_i);
        reg_req_o = '{rd: !w, wr: w, addr: a, wdata: d};
        for (i = 0; i < 4 && !ok; i++) begin
            @(negedge clk_sys_i);
            if (reg_rsp_i.ack === 1'b1) begin
                ok = 1'b1;
                err = reg_rsp_i.err;
                q = reg_rsp_i.rdata;
            end
            reg_req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        end
    endtask : reg_acc
endmodule : mrs_master_model

// *** testbench/testbench.sv ***
/* self-checking bench for mrs_comms_cfg with a shortened second.
   assumes the master model drives the register port and telegrams. */
`timescale 1ns/1ps
module testbench import mrs_pkg::*;;
    typedef struct {logic w; logic [15:0] a; logic [15:0] d; logic e; logic [15:0] q;} mrs_row_t;
    logic clk_sys_i;
    logic resetn_i;
    logic ramp_done_i;
    mrs_reg_req_t req;
    mrs_reg_rsp_t rsp;
    mrs_frame_cfg_t fcfg;
    logic fv, for_me, go, loss, trip, rstop, spd, rbus;
    logic [7:0] fa;
    logic [15:0] hb;
    int n_mismatch = 0;
    int checked = 0;
    int n, i, k;
    logic e, tr;
    logic [15:0] q;
    int baud [6] = '{9600, 19200, 38400, 57600, 76800, 115200};
    logic [2:0] fexp [4] = '{3'h0, 3'h1, 3'h6, 3'h4};
    // reset values first, then refusals of every field
    mrs_row_t rows [25] = '{
        '{0, 16'h0259, 0, 0, 1}, '{0, 16'h025a, 0, 0, 5}, '{0, 16'h025b, 0, 0, 0},
        '{0, 16'h025c, 0, 0, 5}, '{0, 16'h025d, 0, 0, 0}, '{0, 16'h025e, 0, 0, 0},
        '{0, 16'h025f, 0, 0, 0}, '{0, 16'h0258, 0, 1, 0}, '{0, 16'h0260, 0, 1, 0},
        '{1, 16'h0259, 0, 1, 0}, '{1, 16'h0259, 16'h0040, 1, 0}, '{1, 16'h0259, 16'h003f, 0, 0},
        '{0, 16'h0259, 0, 0, 16'h003f}, '{1, 16'h025a, 6, 1, 0}, '{1, 16'h025b, 4, 1, 0},
        '{1, 16'h025c, 16'h003d, 1, 0}, '{1, 16'h025d, 4, 1, 0}, '{1, 16'h025e, 2, 1, 0},
        '{1, 16'h025f, 16'h0011, 1, 0}, '{1, 16'h025f, 16'h0010, 0, 0},
        '{0, 16'h025f, 0, 0, 16'h0010}, '{1, 16'h025e, 1, 0, 0}, '{0, 16'h025e, 0, 0, 1},
        '{1, 16'h0259, 7, 0, 0}, '{1, 16'h025f, 0, 0, 0}};

    always #4 clk_sys_i = ~clk_sys_i;

    mrs_comms_cfg #(.CLK_PER_SEC(100)) i_dut (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_req_i(req), .reg_rsp_o(rsp),
        .frame_valid_i(fv), .frame_addr_i(fa), .ramp_done_i(ramp_done_i),
        .frame_for_me_o(for_me), .reply_go_o(go), .half_bit_cycles_o(hb),
        .frame_cfg_o(fcfg), .ramp_from_bus_o(rbus), .comm_loss_o(loss), .trip_o(trip),
        .ramp_stop_o(rstop), .signal_loss_speed_o(spd));
    mrs_master_model i_master (.clk_sys_i(clk_sys_i), .reg_rsp_i(rsp), .reg_req_o(req),
        .frame_valid_o(fv), .frame_addr_o(fa));

    task automatic check1(input string s, input logic x, input logic g);
        checked++;
        if (g !== x) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", s, x, g);
        end
    endtask : check1
    task automatic check16(input string s, input logic [15:0] x, input logic [15:0] g);
        checked++;
        if (g !== x) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", s, x, g);
        end
    endtask : check16
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
        logic ok;
        i_master.reg_acc(w, a, d, ok, e, q);
        check1("ack", 1'b1, ok);
    endtask : acc
    task automatic wait_neg(input int c);
        repeat (c) @(negedge clk_sys_i);
    endtask : wait_neg
    task automatic finish_test();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    initial begin
        repeat (70000) @(posedge clk_sys_i);
        n_mismatch++;
        finish_test();
    end

    initial begin
        clk_sys_i = 1'b0;
        resetn_i = 1'b0;
        ramp_done_i = 1'b0;
        repeat (4) @(posedge clk_sys_i);
        @(negedge clk_sys_i) resetn_i = 1'b1;
        wait_neg(600);
        check1("idle loss", 1'b0, loss);
        foreach (rows[r]) begin
            acc(rows[r].w, rows[r].a, rows[r].d);
            check1("err", rows[r].e, e);
            if (!rows[r].w) check16("rdata", rows[r].q, q);
        end
        check1("ramp source", 1'b1, rbus);
        // ------------------------------------------------------------
        // rate and framing codes
        // ------------------------------------------------------------
        for (k = 0; k < 6; k++) begin
            acc(1'b1, 16'h025a, 16'(k));
            wait_neg(1);
            check16("half bit", 16'((125000000 + 2 * baud[k] - 1) / (2 * baud[k])), hb);
        end
        for (k = 0; k < 4; k++) begin
            acc(1'b1, 16'h025b, 16'(k));
            wait_neg(1);
            check16("framing", {13'h0, fexp[k]}, {13'h0, fcfg});
        end
        i_master.send_frame(8'h07);
        check1("match", 1'b1, for_me);
        i_master.send_frame(8'h00);
        check1("addr zero", 1'b0, for_me);
        i_master.send_frame(8'h08);
        check1("other addr", 1'b0, for_me);
        // ------------------------------------------------------------
        // link loss: one second of 100 cycles, every action code
        // ------------------------------------------------------------
        acc(1'b1, 16'h025c, 16'h0001);
        for (k = 0; k < 4; k++) begin
            acc(1'b1, 16'h025d, 16'(k));
            i_master.send_frame(8'h07);
            n = 0;
            tr = 1'b0;
            while (loss !== 1'b1 && n < 120) begin
                @(negedge clk_sys_i);
                n++;
                tr = tr | trip;
            end
            check1("loss time", 1'b1, n >= 95 && n <= 104);
            check1("trip", k == 0, tr);
            check1("ramp stop", k == 1 || k == 2, rstop);
            check1("loss speed", k == 3, spd);
            tr = 1'b0;
            @(negedge clk_sys_i) ramp_done_i = 1'b1;
            @(negedge clk_sys_i) ramp_done_i = 1'b0;
            for (i = 0; i < 3; i++) begin
                tr = tr | trip;
                @(negedge clk_sys_i);
            end
            check1("trip after ramp", k == 1, tr);
            i_master.send_frame(8'h07);
            wait_neg(3);
            check1("loss cleared", 1'b0, loss);
        end
        acc(1'b1, 16'h025c, 16'h0000);
        i_master.send_frame(8'h07);
        wait_neg(300);
        check1("zero timeout", 1'b0, loss);
        acc(1'b1, 16'h025c, 16'h0001);
        for (k = 0; k < 3; k++) begin
            i_master.send_frame(8'h07);
            wait_neg(80);
        end
        check1("restart", 1'b0, loss);
        acc(1'b1, 16'h025c, 16'h0000);
        // ------------------------------------------------------------
        // reply gap: 115.2k, even parity, one extra character
        // ------------------------------------------------------------
        acc(1'b1, 16'h025f, 16'h0001);
        i_master.send_frame(8'h07);
        n = 0;
        while (go !== 1'b1 && n < 60000) begin
            @(negedge clk_sys_i);
            n++;
        end
        k = (7 + 2) * 11 * ((125000000 + 230400 - 1) / 230400);
        check1("reply gap", 1'b1, n >= k - 2 && n <= k + 5);
        // mid-run reset restores defaults
        resetn_i = 1'b0;
        wait_neg(2);
        resetn_i = 1'b1;
        acc(1'b0, 16'h025e, 16'h0000);
        check16("ramp reset", 16'h0000, q);
        finish_test();
    end
endmodule : testbench
